// ==== bench/radio_test_status_regs_tb_top.sv ====
`timescale 1ns/1ps
module radio_test_status_regs_tb_top;
	import rts_pkg::*;
	localparam logic [7:0] PART_ID = 8'h6e; // arbitrary
	localparam logic [7:0] REV_ID = 8'h2d; // arbitrary
	logic ref_clk = 0;
	logic rst_b = 0;
	rts_radio_t radio = '0;
	rts_req_t req;
	logic [7:0] rdData, v, q, keep;
	logic rdValid;
	rts_analog_t analog;
	int failures = 0, total_checks = 0, seed = 92872, sum = 0;
	logic [15:0] rstTab [10] = '{16'ha800, 16'ha959, 16'haa7f, 16'hab3f, 16'hac88, 16'had31,
		16'hae0b, {8'hf0, PART_ID}, {8'hf1, REV_ID}, 16'hb000};
	logic [15:0] wakeTab [4] = '{16'hac88, 16'had31, 16'haa7f, 16'hae0b};
	logic [5:0] wa [5] = '{6'h28, 6'h2a, 6'h2c, 6'h2d, 6'h2e};
	initial forever #2 ref_clk = ~ref_clk;
	rts_host_model rts_host_model_i (.ref_clk(ref_clk), .req(req));
	rts_regs #(.PART_NUMBER(PART_ID), .REVISION(REV_ID)) rts_regs_i (.ref_clk(ref_clk),
		.rst_b(rst_b), .req(req), .radio(radio), .rdData(rdData), .rdValid(rdValid),
		.analog(analog));
	// expected analog copy after wake-up: retention flips a few bits
	function automatic logic [7:0] trimCopy(input logic ret, input logic isA);
		return isA ? (ret ? 8'h81 : 8'h88) : (ret ? 8'h35 : 8'h31);
	endfunction
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// read is answered one edge after it is taken
	task automatic rd(input logic [7:0] hdr, input logic [7:0] exp);
		rts_host_model_i.access(hdr, 8'h00);
		#1 chk("rdValid", 8'h01, {7'h0, rdValid});
		chk($sformatf("read %h", hdr), exp, rdData);
	endtask
	task automatic results();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// ten thousand cycles are plenty for the whole sequence
	initial begin
		#40000;
		failures++;
		results();
	end
	initial begin
		repeat (6) @(posedge ref_clk);
		rst_b <= 1'b1;
		foreach (rstTab[i]) rd(rstTab[i][15:8], rstTab[i][7:0]);
		rts_host_model_i.access(8'h30, 8'hff);
		rd(8'hf0, PART_ID);
		$display("test reset and identity done");
		@(posedge ref_clk) radio.idle <= 1'b1;
		rts_host_model_i.access(8'h2a, TEMP_SENSOR_CODE);
		#1 chk("tempSensorEnable", 8'h01, {7'h0, analog.tempSensorEnable});
		// default goes back while still idle, as the host must
		rts_host_model_i.access(8'h2a, PRODUCTION_TEST_RST);
		#1 chk("tempSensorEnable", 8'h00, {7'h0, analog.tempSensorEnable});
		@(posedge ref_clk) radio.idle <= 1'b0;
		$display("test temperature sensor done");
		for (int r = 0; r < 2; r++) begin
			foreach (wa[i]) begin
				v = 8'($random(seed));
				if (wa[i] == 6'h28) keep = v & 8'h7f;
				rts_host_model_i.access({2'b00, wa[i]}, v);
				rd({2'b10, wa[i]}, wa[i] == 6'h28 ? v & 8'h7f : v);
			end
			@(posedge ref_clk) radio.sleeping <= 1'b1;
			// refused while asleep; rc trim is not restored, so a taken write would show
			rts_host_model_i.access(8'h28, ~keep);
			@(posedge ref_clk);
			radio.sleeping <= 1'b0;
			radio.wakeUp <= 1'b1;
			radio.retentionOption <= r[0];
			@(posedge ref_clk) radio.wakeUp <= 1'b0;
			#1 chk("analogTrimA", trimCopy(r[0], 1'b1), analog.analogTrimA);
			chk("analogTrimB", trimCopy(r[0], 1'b0), analog.analogTrimB);
			chk("rcOscTrimLow", keep, analog.rcOscTrimLow);
			chk("oscSelectCalEnable", 8'h01, {7'h0, analog.oscSelectCalEnable});
			rd(8'ha8, keep);
			foreach (wakeTab[i]) rd(wakeTab[i][15:8], wakeTab[i][7:0]);
		end
		$display("test sleep and wake done");
		for (int i = 0; i < 4; i++) begin
			v = (i == 0) ? 8'h80 : 8'($random(seed));
			@(posedge ref_clk);
			radio.freqValid <= 1'b1;
			radio.carrierOffset <= v;
			@(posedge ref_clk) radio.freqValid <= 1'b0;
			rd(8'hf2, v);
			@(posedge ref_clk) radio.amplitudeMod <= 1'b1;
			rd(8'hf2, 8'h00);
			@(posedge ref_clk) radio.amplitudeMod <= 1'b0;
		end
		$display("test frequency offset done");
		@(posedge ref_clk) radio.syncFound <= 1'b1;
		for (int i = 0; i < LQ_SYMBOLS; i++) begin
			q = 8'($random(seed));
			@(posedge ref_clk);
			radio.syncFound <= 1'b0;
			radio.symbolStrobe <= 1'b1;
			radio.symbolQuality <= q[6:0];
			sum += q[6:0];
		end
		@(posedge ref_clk);
		radio.symbolStrobe <= 1'b0;
		radio.crcDone <= 1'b1;
		radio.crcMatch <= q[7];
		@(posedge ref_clk) radio.crcDone <= 1'b0;
		rd(8'hf3, {q[7], sum[12:6]});
		@(posedge ref_clk) radio.rxEnter <= 1'b1;
		@(posedge ref_clk) radio.rxEnter <= 1'b0;
		rd(8'hf3, {1'b0, sum[12:6]});
		$display("test link quality done");
		results();
	end
endmodule

// ==== bench/rts_host_model.sv ====
`timescale 1ns/1ps
// host side of the register port: one byte request per call, none for writes to 0x29 or 0x2B
module rts_host_model (
	input wire logic ref_clk,
	output rts_pkg::rts_req_t req
);
	import rts_pkg::*;
	initial req = '0;
	// hold the request one edge, then scramble the released lines
	task automatic access(input logic [7:0] hdr, input logic [7:0] wd);
		if (!hdr[7] && (hdr[5:0] == SYNTH_CAL_TEST_OFS || hdr[5:0] == GAIN_CTRL_TEST_OFS)) begin
			return;
		end
		@(posedge ref_clk);
		req <= '{valid: 1'b1, header: hdr, wrData: wd};
		@(posedge ref_clk);
		req <= '{valid: 1'b0, header: ~hdr, wrData: ~wd};
	endtask
endmodule

// ==== bench/rts_regs_properties.sv ====
`timescale 1ns/1ps
// port-level watch on answers and wake-up forcing
module rts_regs_checker (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire rts_pkg::rts_req_t req,
	input wire rts_pkg::rts_radio_t radio,
	input wire logic [7:0] rdData,
	input wire logic rdValid,
	input wire rts_pkg::rts_analog_t analog
);
	import rts_pkg::*;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	a_read_answer: assert property (
		req.valid && req.header[7] && !radio.sleeping |=> rdValid) else $error("read lost");
	a_no_stray: assert property (
		!(req.valid && req.header[7] && !radio.sleeping) |=> !rdValid) else $error("stray answer");
	a_temp_idle: assert property (
		analog.tempSensorEnable |-> $past(radio.idle)) else $error("sensor on outside idle");
	a_wake_trim_a: assert property (
		radio.wakeUp |=> analog.analogTrimA == ($past(radio.retentionOption) ?
		ANALOG_TRIM_A_RETAIN : ANALOG_TRIM_A_RST)) else $error("trim a copy wrong");
	a_wake_trim_b: assert property (
		radio.wakeUp |=> analog.analogTrimB == ($past(radio.retentionOption) ?
		ANALOG_TRIM_B_RETAIN : ANALOG_TRIM_B_RST)) else $error("trim b copy wrong");
	a_wake_tests: assert property (
		radio.wakeUp |=> analog.synthCalTest == SYNTH_CAL_TEST_RST && analog.gainCtrlTest ==
		GAIN_CTRL_TEST_RST && analog.analogTrimC == ANALOG_TRIM_C_RST) else $error("not restored");
	a_osc_cal_bit: assert property (
		req.valid && !req.header[7] && req.header[5:0] == ANALOG_TRIM_C_OFS && !radio.sleeping
		&& !radio.wakeUp |=> analog.oscSelectCalEnable == $past(req.wrData[OSC_SELECT_CAL_BIT])
		&& analog.analogTrimC[OSC_SELECT_CAL_BIT] == $past(req.wrData[OSC_SELECT_CAL_BIT]))
		else $error("cal bit");
	a_freq_zero: assert property (
		req.valid && req.header == 8'hf2 && radio.amplitudeMod && !radio.sleeping
		|=> rdData == 8'h00) else $error("offset not zero");
endmodule
bind rts_regs rts_regs_checker rts_regs_checker_i (.ref_clk(ref_clk), .rst_b(rst_b),
	.req(req), .radio(radio), .rdData(rdData), .rdValid(rdValid), .analog(analog));

// ==== hdl/rts_pkg.sv ====
package rts_pkg;

	// register header byte fields: bit 7 read, bit 6 burst/status form, 5:0 address
	localparam int HDR_READ_BIT = 7;
	localparam int HDR_BURST_BIT = 6;
	localparam int ADDR_W = 6;
	localparam int DATA_W = 8;

	// register offsets
	localparam logic [5:0] RC_OSC_TRIM_LOW_OFS = 6'h28;
	localparam logic [5:0] SYNTH_CAL_TEST_OFS = 6'h29;
	localparam logic [5:0] PRODUCTION_TEST_OFS = 6'h2a;
	localparam logic [5:0] GAIN_CTRL_TEST_OFS = 6'h2b;
	localparam logic [5:0] ANALOG_TRIM_A_OFS = 6'h2c;
	localparam logic [5:0] ANALOG_TRIM_B_OFS = 6'h2d;
	localparam logic [5:0] ANALOG_TRIM_C_OFS = 6'h2e;
	localparam logic [5:0] PART_NUMBER_ID_OFS = 6'h30;
	localparam logic [5:0] REVISION_ID_OFS = 6'h31;
	localparam logic [5:0] FREQ_OFFSET_EST_OFS = 6'h32;
	localparam logic [5:0] LINK_QUALITY_EST_OFS = 6'h33;

	// values after reset and wake-up
	localparam logic [7:0] RC_OSC_TRIM_LOW_RST = 8'h00;
	localparam logic [7:0] RC_OSC_TRIM_LOW_MASK = 8'h7f;
	localparam logic [7:0] SYNTH_CAL_TEST_RST = 8'h59;
	localparam logic [7:0] PRODUCTION_TEST_RST = 8'h7f;
	localparam logic [7:0] GAIN_CTRL_TEST_RST = 8'h3f;
	localparam logic [7:0] ANALOG_TRIM_A_RST = 8'h88;
	localparam logic [7:0] ANALOG_TRIM_A_RETAIN = 8'h81;
	localparam logic [7:0] ANALOG_TRIM_B_RST = 8'h31;
	localparam logic [7:0] ANALOG_TRIM_B_RETAIN = 8'h35;
	localparam logic [7:0] ANALOG_TRIM_C_RST = 8'h0b;
	localparam int OSC_SELECT_CAL_BIT = 1;

	// temperature sensor unlock code in the production test register
	localparam logic [7:0] TEMP_SENSOR_CODE = 8'hbf;

	// link quality layout
	localparam int CRC_OK_BIT = 7;
	localparam int LQ_SYMBOLS = 64;
	localparam int LQ_SHIFT = 6;
	localparam int LQ_CNT_W = 7;
	localparam int LQ_ACC_W = 13;

	// register access request from the serial port front end
	typedef struct packed {
		logic valid;
		logic [7:0] header;
		logic [7:0] wrData;
	} rts_req_t;

	// radio events seen by this block
	typedef struct packed {
		logic sleeping;
		logic wakeUp;
		logic idle;
		logic retentionOption;
		logic amplitudeMod;
		logic rxEnter;
		logic crcDone;
		logic crcMatch;
		logic freqValid;
		logic [7:0] carrierOffset;
		logic syncFound;
		logic symbolStrobe;
		logic [6:0] symbolQuality;
	} rts_radio_t;

	// trim values driven into the analog part
	typedef struct packed {
		logic [7:0] rcOscTrimLow;
		logic [7:0] synthCalTest;
		logic [7:0] gainCtrlTest;
		logic [7:0] analogTrimA;
		logic [7:0] analogTrimB;
		logic [7:0] analogTrimC;
		logic oscSelectCalEnable;
		logic tempSensorEnable;
	} rts_analog_t;

endpackage

// ==== hdl/rts_regs.sv ====
// Behaviour
// - test registers 0x29-0x2E lose contents in sleep, restored on wake-up.
// - production test holding 0xBF enables temperature sensor while idle.
// - wake-up forces analog copy of trim A to 0x88 or 0x81 by retention.
// - trim A reads 0x88 after wake-up; inversion only in analog copy.
// - wake-up forces analog copy of trim B to 0x31 or 0x35 by retention.
// - trim B reads 0x31 after wake-up; inversion only in analog copy.
// - trim C bit 1, reset one, enables oscillator selection calibration stage.
// - frequency offset estimate is eight-bit two's complement carrier offset.
// - frequency offset estimate reads zero under amplitude or on-off keying.
// - link quality bit 7 is last checksum match, cleared on receive entry.
// - link quality bits 6:0 estimate demodulation ease over 64 post-sync symbols.
// - part number and revision are read-only at status addresses 0xF0, 0xF1.
`timescale 1ns/1ps

module rts_regs #(
	parameter logic [7:0] PART_NUMBER = 8'h5a, // arbitrary value
	parameter logic [7:0] REVISION = 8'h3c // arbitrary value
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire rts_pkg::rts_req_t req,
	input wire rts_pkg::rts_radio_t radio,
	output logic [7:0] rdData,
	output logic rdValid,
	output rts_pkg::rts_analog_t analog
);
	import rts_pkg::*;

	// whole block state, registered in one place
	typedef struct packed {
		logic [7:0] rcOscTrimLow;
		logic [7:0] synthCalTest;
		logic [7:0] productionTest;
		logic [7:0] gainCtrlTest;
		logic [7:0] trimA;
		logic [7:0] trimB;
		logic [7:0] trimC;
		logic [7:0] trimAInt;
		logic [7:0] trimBInt;
		logic [7:0] freq_offset_estimate;
		logic crcOk;
		logic [6:0] lqValue;
		logic lqActive;
		logic [LQ_CNT_W-1:0] lqCount;
		logic [LQ_ACC_W-1:0] lqAccum;
		logic [7:0] rdData;
		logic rdValid;
		logic tempEn;
	} rts_state_t;

	rts_state_t state_q;
	rts_state_t state_d;

	logic isRead;
	logic isBurst;
	logic [5:0] addr;
	logic [7:0] readMux;
	logic [LQ_ACC_W-1:0] accumNext;

	// header decode
	assign isRead = req.header[HDR_READ_BIT];
	assign isBurst = req.header[HDR_BURST_BIT];
	assign addr = req.header[ADDR_W-1:0];

	// read data selection; status form needs the burst bit at 0x30 and up
	always_comb begin
		readMux = 8'h00;
		if (addr == RC_OSC_TRIM_LOW_OFS) begin
			readMux = state_q.rcOscTrimLow & RC_OSC_TRIM_LOW_MASK;
		end else if (addr == SYNTH_CAL_TEST_OFS) begin
			readMux = state_q.synthCalTest;
		end else if (addr == PRODUCTION_TEST_OFS) begin
			readMux = state_q.productionTest;
		end else if (addr == GAIN_CTRL_TEST_OFS) begin
			readMux = state_q.gainCtrlTest;
		end else if (addr == ANALOG_TRIM_A_OFS) begin
			readMux = state_q.trimA;
		end else if (addr == ANALOG_TRIM_B_OFS) begin
			readMux = state_q.trimB;
		end else if (addr == ANALOG_TRIM_C_OFS) begin
			readMux = state_q.trimC;
		end else if (isBurst && addr == PART_NUMBER_ID_OFS) begin
			readMux = PART_NUMBER;
		end else if (isBurst && addr == REVISION_ID_OFS) begin
			readMux = REVISION;
		end else if (isBurst && addr == FREQ_OFFSET_EST_OFS) begin
			// offset estimation is meaningless without frequency keying
			readMux = radio.amplitudeMod ? 8'h00 : state_q.freq_offset_estimate;
		end else if (isBurst && addr == LINK_QUALITY_EST_OFS) begin
			readMux = {state_q.crcOk, state_q.lqValue};
		end
	end

	// next-state logic
	always_comb begin
		state_d = state_q;
		state_d.rdValid = 1'b0;
		accumNext = state_q.lqAccum + LQ_ACC_W'(radio.symbolQuality);

		// host access; ignored while asleep since the port is down then
		if (req.valid && !radio.sleeping) begin
			if (isRead) begin
				state_d.rdData = readMux;
				state_d.rdValid = 1'b1;
			end else if (addr == RC_OSC_TRIM_LOW_OFS) begin
				state_d.rcOscTrimLow = req.wrData & RC_OSC_TRIM_LOW_MASK;
			end else if (addr == SYNTH_CAL_TEST_OFS) begin
				state_d.synthCalTest = req.wrData;
			end else if (addr == PRODUCTION_TEST_OFS) begin
				state_d.productionTest = req.wrData;
			end else if (addr == GAIN_CTRL_TEST_OFS) begin
				state_d.gainCtrlTest = req.wrData;
			end else if (addr == ANALOG_TRIM_A_OFS) begin
				state_d.trimA = req.wrData;
				state_d.trimAInt = req.wrData;
			end else if (addr == ANALOG_TRIM_B_OFS) begin
				state_d.trimB = req.wrData;
				state_d.trimBInt = req.wrData;
			end else if (addr == ANALOG_TRIM_C_OFS) begin
				state_d.trimC = req.wrData;
			end
			// writes to 0x30 and above fall through untouched
		end

		// wake-up restores the volatile test registers
		if (radio.wakeUp) begin
			state_d.synthCalTest = SYNTH_CAL_TEST_RST;
			state_d.productionTest = PRODUCTION_TEST_RST;
			state_d.gainCtrlTest = GAIN_CTRL_TEST_RST;
			state_d.trimA = ANALOG_TRIM_A_RST;
			state_d.trimB = ANALOG_TRIM_B_RST;
			state_d.trimC = ANALOG_TRIM_C_RST;
			// only the analog copies see the retention variant
			state_d.trimAInt = radio.retentionOption ? ANALOG_TRIM_A_RETAIN
				: ANALOG_TRIM_A_RST;
			state_d.trimBInt = radio.retentionOption ? ANALOG_TRIM_B_RETAIN
				: ANALOG_TRIM_B_RST;
		end

		// sensor follows the unlock code only while idle
		state_d.tempEn = radio.idle && (state_d.productionTest == TEMP_SENSOR_CODE);

		// latest demodulator offset estimate
		if (radio.freqValid) begin
			state_d.freq_offset_estimate = radio.carrierOffset;
		end

		// checksum result; a result in the entry cycle wins over the clear
		if (radio.crcDone) begin
			state_d.crcOk = radio.crcMatch;
		end else if (radio.rxEnter) begin
			state_d.crcOk = 1'b0;
		end

		// average per-symbol quality over the symbols after sync
		if (radio.rxEnter) begin
			state_d.lqActive = 1'b0;
		end else if (radio.syncFound) begin
			state_d.lqActive = 1'b1;
			state_d.lqCount = '0;
			state_d.lqAccum = '0;
		end else if (state_q.lqActive && radio.symbolStrobe) begin
			state_d.lqAccum = accumNext;
			state_d.lqCount = state_q.lqCount + LQ_CNT_W'(1);
			if (state_q.lqCount == LQ_CNT_W'(LQ_SYMBOLS - 1)) begin
				// a 13-bit sum of 64 seven-bit values shifted by 6 fits in 7 bits
				state_d.lqValue = accumNext[LQ_SHIFT +: 7];
				state_d.lqActive = 1'b0;
			end
		end
	end

	// state register
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= '0;
			state_q.rcOscTrimLow <= RC_OSC_TRIM_LOW_RST;
			state_q.synthCalTest <= SYNTH_CAL_TEST_RST;
			state_q.productionTest <= PRODUCTION_TEST_RST;
			state_q.gainCtrlTest <= GAIN_CTRL_TEST_RST;
			state_q.trimA <= ANALOG_TRIM_A_RST;
			state_q.trimB <= ANALOG_TRIM_B_RST;
			state_q.trimC <= ANALOG_TRIM_C_RST;
			state_q.trimAInt <= ANALOG_TRIM_A_RST;
			state_q.trimBInt <= ANALOG_TRIM_B_RST;
		end else begin
			state_q <= state_d;
		end
	end

	// outputs straight from the state register
	assign rdData = state_q.rdData;
	assign rdValid = state_q.rdValid;
	assign analog.rcOscTrimLow = state_q.rcOscTrimLow;
	assign analog.synthCalTest = state_q.synthCalTest;
	assign analog.gainCtrlTest = state_q.gainCtrlTest;
	assign analog.analogTrimA = state_q.trimAInt;
	assign analog.analogTrimB = state_q.trimBInt;
	assign analog.analogTrimC = state_q.trimC;
	assign analog.oscSelectCalEnable = state_q.trimC[OSC_SELECT_CAL_BIT];
	assign analog.tempSensorEnable = state_q.tempEn;

endmodule
